// *** shared/gtof_pkg.sv ***
package gtof_pkg;

  // ASCII characters used by the formatter and the command parser
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_DEL    = 8'h7f;
  localparam logic [7:0] CH_SP     = 8'h20;
  localparam logic [7:0] CH_PLUS   = 8'h2b;
  localparam logic [7:0] CH_MINUS  = 8'h2d;
  localparam logic [7:0] CH_COMMA  = 8'h2c;
  localparam logic [7:0] CH_SLASH  = 8'h2f;
  localparam logic [7:0] CH_LOW_E  = 8'h65;
  localparam logic [7:0] CH_0      = 8'h30;
  localparam logic [7:0] CH_1      = 8'h31;
  localparam logic [7:0] CH_9      = 8'h39;
  localparam logic [7:0] CH_CAP_A  = 8'h41;
  localparam logic [7:0] CH_CAP_Z  = 8'h5a;
  localparam logic [7:0] CH_U      = 8'h55;
  localparam logic [7:0] CH_G      = 8'h47;
  localparam logic [7:0] CH_Y      = 8'h59;
  localparam logic [7:0] CH_S      = 8'h53;
  localparam logic [7:0] CH_N      = 8'h4e;
  localparam logic [7:0] CH_O      = 8'h4f;
  localparam logic [7:0] CH_D      = 8'h44;
  localparam logic [7:0] CH_P      = 8'h50;

  // Printable form of the terminator field
  localparam logic [7:0] TERM_LOW_MASK  = 8'h0f;
  localparam logic [7:0] TERM_PRINT_SET = 8'h30;

  // Status byte bit positions
  localparam int SB_OVERFLOW    = 0;
  localparam int SB_ILLEGAL_OPT = 0;
  localparam int SB_ILLEGAL_CMD = 1;
  localparam int SB_DONE        = 3;
  localparam int SB_BUSY        = 4;
  localparam int SB_ERROR       = 5;
  localparam int SB_SRQ         = 6;

  // Message layout
  localparam int MSG_DEPTH  = 20;
  localparam int IDX_W      = 5;
  localparam int PREFIX_LEN = 4;
  localparam int MANT_LEN   = 8;
  localparam int EXP_LEN    = 3;
  localparam int MODE_LEN   = 8;

  // Status word prefix; the value is arbitrary
  localparam logic [31:0] STATUS_PREFIX = 32'h53_54_41_54;

  // Talk-only free-running rate: about three readings per second
  localparam int unsigned TALK_PERIOD_MS = 333;
  localparam int unsigned CLOCK_KHZ      = 250000;
  localparam int unsigned TALK_PERIOD_CYC = TALK_PERIOD_MS * CLOCK_KHZ;
  localparam int          RATE_W          = 27;
  localparam int          STRAP_WAIT      = 3;

  typedef enum logic [1:0] {
    MEAS_STANDBY  = 2'h0,
    MEAS_NORMAL   = 2'h1,
    MEAS_OVERFLOW = 2'h2,
    MEAS_ZERO     = 2'h3
  } gtof_meas_type;

  typedef enum logic [3:0] {
    TERM_CRLF   = 4'b0001,
    TERM_LFCR   = 4'b0010,
    TERM_SINGLE = 4'b0100,
    TERM_NONE   = 4'b1000
  } gtof_term_type;

  typedef enum logic [3:0] {
    PARSE_IDLE = 4'b0001,
    PARSE_U    = 4'b0010,
    PARSE_G    = 4'b0100,
    PARSE_Y    = 4'b1000
  } gtof_parse_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } gtof_tx_type;

endpackage

// *** core/gtof_sync.sv ***
`timescale 1ns/1ps
module gtof_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

// *** core/gtof_rate_tick.sv ***
`timescale 1ns/1ps
module gtof_rate_tick
  import gtof_pkg::*;
#(
  parameter int unsigned PERIOD = TALK_PERIOD_CYC
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic enable,
  output logic      tick
);
  logic [RATE_W-1:0] count_ff;
  localparam logic [RATE_W-1:0] LAST = RATE_W'(PERIOD - 1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
      tick     <= 1'b0;
    end else if (!enable) begin
      count_ff <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (count_ff == LAST);
      count_ff <= (count_ff == LAST) ? '0 : count_ff + 1'b1;
    end
  end
endmodule

// *** core/gtof_formatter.sv ***
`timescale 1ns/1ps
module gtof_formatter #(
  parameter int unsigned TALK_PERIOD = gtof_pkg::TALK_PERIOD_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        foreign_illegal_cmd,
  input  wire logic        dev_clear,
  input  wire logic        talk_addressed,
  input  wire logic        status_byte_read,
  input  wire logic        srq_pending,
  input  wire logic [7:0]  srq_mask,
  input  wire logic [63:0] mode_digits,
  input  wire logic        line_50hz,
  input  wire logic        busy_in,
  input  wire logic        reading_valid,
  input  wire logic [1:0]  meas_state,
  input  wire logic        meas_negative,
  input  wire logic        dry_circuit,
  input  wire logic        pulsed_drive,
  input  wire logic [63:0] mantissa,
  input  wire logic [23:0] exponent,
  input  wire logic        talk_only_position,
  input  wire logic [4:0]  address_switch,
  input  wire logic        one_shot_mode,
  input  wire logic        single_press,
  input  wire logic        ext_trigger,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  output logic             talk_only_active,
  output logic             prefix_enabled,
  output logic             status_word_pending,
  output logic             illegal_command_flag,
  output logic             illegal_option_flag,
  output logic [7:0]       status_byte
);
  import gtof_pkg::*;

  function automatic logic refused_term(input logic [7:0] c);
    refused_term = (c >= CH_CAP_A && c <= CH_CAP_Z) ||
                   (c >= CH_0 && c <= CH_9) ||
                   c == CH_SP || c == CH_PLUS || c == CH_SLASH ||
                   c == CH_COMMA || c == CH_LOW_E;
  endfunction

  function automatic logic [15:0] two_digits(input logic [7:0] v);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = v / 8'd10;
    ones = v % 8'd10;
    two_digits = {tens + CH_0, ones + CH_0};
  endfunction

  // Straps and pins
  logic [4:0]    addr_sync;
  logic          talk_only_sync;
  logic [1:0]    trig_sync;
  logic [1:0]    strap_wait_ff;
  logic          strap_done_ff;
  logic          addr_odd_ff;
  logic          trig_prev_ff;
  logic          trig_edge;

  // Command state
  gtof_parse_type parse_ff;
  gtof_term_type  term_mode_ff;
  logic [7:0]     term_char_ff;
  logic           cmd_ok;

  // Reading capture
  logic [31:0]    read_prefix_ff;
  logic [63:0]    mant_ff;
  logic [23:0]    exp_ff;
  logic           reading_done_ff;
  logic           overflow_ff;

  // Talk-only scheduling
  logic           rate_tick;
  logic           free_due_ff;
  logic           trig_pend_ff;
  logic           shot_due_ff;

  // Transmitter
  gtof_tx_type     tx_state_ff;
  logic [7:0]      msg_ff [MSG_DEPTH];
  logic [IDX_W-1:0] len_ff;
  logic [IDX_W-1:0] idx_ff;
  logic [7:0]      nxt_msg [MSG_DEPTH];
  logic [IDX_W-1:0] nxt_len;
  logic            start_fire;
  logic            start_status;
  logic            with_prefix;
  logic            accept;
  logic [7:0]      term_field;
  logic [15:0]     mask_digits;

  gtof_sync #(.WIDTH(6)) u_strap_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({talk_only_position, address_switch}),
    .sync_out ({talk_only_sync, addr_sync})
  );

  gtof_sync #(.WIDTH(2)) u_trig_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({single_press, ext_trigger}),
    .sync_out (trig_sync)
  );

  gtof_rate_tick #(.PERIOD(TALK_PERIOD)) u_rate (
    .clock  (clock),
    .rst_n  (rst_n),
    .enable (talk_only_active && !one_shot_mode),
    .tick   (rate_tick)
  );

  // Strap is caught once, after the synchroniser has filled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait_ff    <= '0;
      strap_done_ff    <= 1'b0;
      talk_only_active <= 1'b0;
      addr_odd_ff      <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_wait_ff <= strap_wait_ff + 1'b1;
      if (strap_wait_ff == 2'(STRAP_WAIT)) begin
        strap_done_ff    <= 1'b1;
        talk_only_active <= talk_only_sync;
        addr_odd_ff      <= addr_sync[0];
      end
    end
  end

  // Bus commands are dropped until the strap is known and in talk-only
  assign cmd_ok = strap_done_ff && !talk_only_active;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      parse_ff <= PARSE_IDLE;
    end else if (cmd_ok && dev_clear) begin
      parse_ff <= PARSE_IDLE;
    end else if (cmd_ok && cmd_valid) begin
      case (parse_ff)
        PARSE_IDLE: begin
          if (cmd_byte == CH_U) begin
            parse_ff <= PARSE_U;
          end else if (cmd_byte == CH_G) begin
            parse_ff <= PARSE_G;
          end else if (cmd_byte == CH_Y) begin
            parse_ff <= PARSE_Y;
          end
        end
        default: parse_ff <= PARSE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prefix_enabled <= 1'b1;
    end else if (cmd_ok && dev_clear) begin
      prefix_enabled <= 1'b1;
    end else if (cmd_ok && cmd_valid && parse_ff == PARSE_G) begin
      if (cmd_byte == CH_0) begin
        prefix_enabled <= 1'b1;
      end else if (cmd_byte == CH_1) begin
        prefix_enabled <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      term_mode_ff <= TERM_CRLF;
      term_char_ff <= CH_LF;
    end else if (cmd_ok && dev_clear) begin
      term_mode_ff <= TERM_CRLF;
      term_char_ff <= CH_LF;
    end else if (cmd_ok && cmd_valid && parse_ff == PARSE_Y) begin
      if (cmd_byte == CH_LF) begin
        term_mode_ff <= TERM_CRLF;
      end else if (cmd_byte == CH_CR) begin
        term_mode_ff <= TERM_LFCR;
      end else if (cmd_byte == CH_DEL) begin
        term_mode_ff <= TERM_NONE;
      end else if (!refused_term(cmd_byte)) begin
        term_mode_ff <= TERM_SINGLE;
        term_char_ff <= cmd_byte;
      end
    end
  end

  // Request survives until the status word actually starts going out
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_word_pending <= 1'b0;
    end else if (cmd_ok && cmd_valid && parse_ff == PARSE_U &&
                 cmd_byte == CH_0) begin
      status_word_pending <= 1'b1;
    end else if (start_fire && start_status) begin
      status_word_pending <= 1'b0;
    end
  end

  // Error flags: a new error in the read cycle wins over the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      illegal_command_flag <= 1'b0;
      illegal_option_flag  <= 1'b0;
    end else begin
      if (cmd_ok && foreign_illegal_cmd) begin
        illegal_command_flag <= 1'b1;
      end else if (status_byte_read) begin
        illegal_command_flag <= 1'b0;
      end
      if (cmd_ok && cmd_valid &&
          ((parse_ff == PARSE_U && cmd_byte != CH_0) ||
           (parse_ff == PARSE_G && cmd_byte != CH_0 && cmd_byte != CH_1) ||
           (parse_ff == PARSE_Y && refused_term(cmd_byte)))) begin
        illegal_option_flag <= 1'b1;
      end else if (status_byte_read) begin
        illegal_option_flag <= 1'b0;
      end
    end
  end

  // Status byte keeps its own data conditions
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reading_done_ff <= 1'b0;
      overflow_ff     <= 1'b0;
    end else begin
      if (reading_valid) begin
        reading_done_ff <= 1'b1;
        overflow_ff     <= (meas_state == MEAS_OVERFLOW);
      end else if (status_byte_read) begin
        reading_done_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_byte <= '0;
    end else begin
      status_byte         <= '0;
      status_byte[SB_SRQ] <= srq_pending;
      if (illegal_command_flag || illegal_option_flag) begin
        status_byte[SB_ERROR]       <= 1'b1;
        status_byte[SB_ILLEGAL_CMD] <= illegal_command_flag;
        status_byte[SB_ILLEGAL_OPT] <= illegal_option_flag;
      end else begin
        status_byte[SB_OVERFLOW] <= overflow_ff;
        status_byte[SB_DONE]     <= reading_done_ff;
        status_byte[SB_BUSY]     <= busy_in;
      end
    end
  end

  // Latest reading, held so a string in flight stays consistent
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_prefix_ff <= {CH_S, CH_PLUS, CH_N, CH_D};
      mant_ff        <= {MANT_LEN{CH_0}};
      exp_ff         <= {EXP_LEN{CH_0}};
    end else if (reading_valid) begin
      case (gtof_meas_type'(meas_state))
        MEAS_STANDBY:  read_prefix_ff[31:24] <= CH_S;
        MEAS_NORMAL:   read_prefix_ff[31:24] <= CH_N;
        MEAS_OVERFLOW: read_prefix_ff[31:24] <= CH_O;
        default:       read_prefix_ff[31:24] <= CH_CAP_Z;
      endcase
      read_prefix_ff[23:16] <= meas_negative ? CH_MINUS : CH_PLUS;
      read_prefix_ff[15:8]  <= dry_circuit ? CH_D : CH_N;
      read_prefix_ff[7:0]   <= pulsed_drive ? CH_P : CH_D;
      mant_ff <= mantissa;
      exp_ff  <= exponent;
    end
  end

  // Talk-only scheduling
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_ff <= 1'b0;
      free_due_ff  <= 1'b0;
      trig_pend_ff <= 1'b0;
      shot_due_ff  <= 1'b0;
    end else begin
      trig_prev_ff <= |trig_sync;
      if (rate_tick) begin
        free_due_ff <= 1'b1;
      end else if (start_fire) begin
        free_due_ff <= 1'b0;
      end
      // One reading per trigger, sent only once the conversion lands
      if (talk_only_active && one_shot_mode && trig_edge) begin
        trig_pend_ff <= 1'b1;
      end else if (reading_valid) begin
        trig_pend_ff <= 1'b0;
      end
      if (trig_pend_ff && reading_valid) begin
        shot_due_ff <= 1'b1;
      end else if (start_fire) begin
        shot_due_ff <= 1'b0;
      end
    end
  end

  assign trig_edge = (|trig_sync) && !trig_prev_ff;

  // Transmit start: addressed talk, or a talk-only event
  always_comb begin
    start_fire   = 1'b0;
    start_status = 1'b0;
    if (tx_state_ff == TX_IDLE && strap_done_ff) begin
      if (talk_only_active) begin
        start_fire = free_due_ff || shot_due_ff;
      end else if (talk_addressed) begin
        start_fire   = 1'b1;
        start_status = status_word_pending;
      end
    end
  end

  // In talk-only the switch LSB replaces the prefix command
  assign with_prefix = talk_only_active ? addr_odd_ff : prefix_enabled;

  always_comb begin
    case (term_mode_ff)
      TERM_CRLF:   term_field = CH_LF;
      TERM_LFCR:   term_field = CH_CR;
      TERM_SINGLE: term_field = term_char_ff;
      default:     term_field = CH_DEL;
    endcase
    term_field = (term_field & TERM_LOW_MASK) | TERM_PRINT_SET;
  end

  // Mask value is already the weighted sum of the enabled bits
  assign mask_digits = two_digits(srq_mask);

  always_comb begin
    int pos;
    pos = 0;
    for (int i = 0; i < MSG_DEPTH; i++) begin
      nxt_msg[i] = CH_SP;
    end
    if (with_prefix) begin
      for (int k = 0; k < PREFIX_LEN; k++) begin
        nxt_msg[pos] = start_status ? STATUS_PREFIX[31-8*k -: 8]
                                    : read_prefix_ff[31-8*k -: 8];
        pos = pos + 1;
      end
    end
    if (start_status) begin
      for (int k = 0; k < MODE_LEN; k++) begin
        nxt_msg[pos] = mode_digits[63-8*k -: 8];
        pos = pos + 1;
      end
      nxt_msg[pos]     = mask_digits[15:8];
      nxt_msg[pos + 1] = mask_digits[7:0];
      nxt_msg[pos + 2] = line_50hz ? CH_1 : CH_0;
      nxt_msg[pos + 3] = term_field;
      pos = pos + 4;
    end else begin
      for (int k = 0; k < MANT_LEN; k++) begin
        nxt_msg[pos] = mant_ff[63-8*k -: 8];
        pos = pos + 1;
      end
      for (int k = 0; k < EXP_LEN; k++) begin
        nxt_msg[pos] = exp_ff[23-8*k -: 8];
        pos = pos + 1;
      end
    end
    case (term_mode_ff)
      TERM_CRLF: begin
        nxt_msg[pos]     = CH_CR;
        nxt_msg[pos + 1] = CH_LF;
        pos = pos + 2;
      end
      TERM_LFCR: begin
        nxt_msg[pos]     = CH_LF;
        nxt_msg[pos + 1] = CH_CR;
        pos = pos + 2;
      end
      TERM_SINGLE: begin
        nxt_msg[pos] = term_char_ff;
        pos = pos + 1;
      end
      default: pos = pos + 0;
    endcase
    nxt_len = IDX_W'(pos);
  end

  assign accept   = (tx_state_ff == TX_SEND) && tx_ready;
  assign tx_valid = (tx_state_ff == TX_SEND);
  assign tx_last  = tx_valid && (idx_ff == len_ff - 1'b1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_ff <= TX_IDLE;
      idx_ff      <= '0;
      len_ff      <= '0;
    end else begin
      case (tx_state_ff)
        TX_IDLE: begin
          if (start_fire) begin
            tx_state_ff <= TX_SEND;
            idx_ff      <= '0;
            len_ff      <= nxt_len;
          end
        end
        TX_SEND: begin
          if (accept) begin
            idx_ff <= idx_ff + 1'b1;
            if (idx_ff == len_ff - 1'b1) begin
              tx_state_ff <= TX_IDLE;
            end
          end
        end
        default: tx_state_ff <= TX_IDLE;
      endcase
    end
  end

  // Message snapshot is taken whole at start so later inputs can't tear it
  always_ff @(posedge clock) begin
    if (start_fire) begin
      msg_ff <= nxt_msg;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_data <= '0;
    end else if (start_fire) begin
      tx_data <= nxt_msg[0];
    end else if (accept && idx_ff != len_ff - 1'b1) begin
      tx_data <= msg_ff[idx_ff + 1'b1];
    end
  end

endmodule

// *** tb/gtof_listener.sv ***
`timescale 1ns/1ps
module gtof_listener (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire logic       clr,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic            got_last
);
  logic [7:0] msg [0:31];
  int         n;
  logic       ph_ff;
  // Slow mode accepts every other cycle to stall the talker
  assign tx_ready = !slow || ph_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= 1'b0;
      n <= 0;
      got_last <= 1'b0;
    end else begin
      ph_ff <= !ph_ff;
      if (clr) begin
        n <= 0;
        got_last <= 1'b0;
      end else if (tx_valid && tx_ready) begin
        msg[n[4:0]] <= tx_data;
        n <= n + 1;
        if (tx_last) got_last <= 1'b1;
      end
    end
  end
endmodule

// *** tb/gtof_formatter_sva.sv ***
`timescale 1ns/1ps
module gtof_formatter_sva (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       dev_clear,
  input wire logic       talk_addressed,
  input wire logic       status_byte_read,
  input wire logic       foreign_illegal_cmd,
  input wire logic       srq_pending,
  input wire logic       tx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire logic       talk_only_active,
  input wire logic       prefix_enabled,
  input wire logic       status_word_pending,
  input wire logic       illegal_command_flag,
  input wire logic       illegal_option_flag,
  input wire logic [7:0] status_byte
);
  import gtof_pkg::*;
  logic [2:0] cnt_ff;
  logic       on;
  // Requests before strap capture are dropped, so checks wait for it
  assign on = (cnt_ff == 3'h7) && !talk_only_active;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 3'h0;
    end else if (cnt_ff != 3'h7) begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_byte_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("byte moved in stall");
  chk_talk_start: assert property (on && talk_addressed && !tx_valid
    |=> tx_valid) else $error("talk did not start");
  chk_last_end: assert property (tx_last && tx_ready |=>
    !tx_valid) else $error("message did not end");
  chk_only_deaf: assert property (talk_only_active && cmd_valid |=>
    $stable(prefix_enabled) && !status_word_pending)
    else $error("command taken in talk-only");
  chk_flag_clear: assert property (status_byte_read && !cmd_valid
    && !foreign_illegal_cmd |=> !illegal_option_flag
    && !illegal_command_flag) else $error("flags not cleared");
  chk_clear_pref: assert property (on && dev_clear |=>
    prefix_enabled) else $error("clear kept prefix off");
  chk_prefix_suppress: assert property (on && cmd_valid
    && cmd_byte == CH_G ##1 cmd_valid && cmd_byte == CH_1 && !dev_clear
    |=> !prefix_enabled) else $error("prefix suppress ignored");
  chk_status_request: assert property (on && cmd_valid
    && cmd_byte == CH_U ##1 cmd_valid && cmd_byte == CH_0 && !talk_addressed
    |=> status_word_pending) else $error("status request lost");
  chk_sb_error: assert property ($rose(illegal_option_flag) |=>
    status_byte[5] && status_byte[0]) else $error("error bits missing");
  chk_sb_srq: assert property (cnt_ff != 3'h0 |->
    status_byte[6] == $past(srq_pending)) else $error("srq bit wrong");
endmodule
bind gtof_formatter gtof_formatter_sva gtof_formatter_sva_inst (.*);

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import gtof_pkg::*;
  logic        clock, rst_n, cmd_valid, foreign_illegal_cmd, dev_clear;
  logic        talk_addressed, status_byte_read, srq_pending, line_50hz;
  logic        busy_in, reading_valid, meas_negative, dry_circuit;
  logic        pulsed_drive, talk_only_position, one_shot_mode;
  logic        single_press, ext_trigger, tx_ready, tx_valid, tx_last;
  logic        talk_only_active, prefix_enabled, status_word_pending;
  logic        illegal_command_flag, illegal_option_flag, slow, clr;
  logic        got_last;
  logic [7:0]  cmd_byte, srq_mask, tx_data, status_byte;
  logic [63:0] mode_digits, mantissa;
  logic [23:0] exponent;
  logic [1:0]  meas_state;
  logic [4:0]  address_switch;
  int          num_errors, total_checks;
  string       cr, lf, rd;
  gtof_formatter #(.TALK_PERIOD(50)) gtof_formatter_inst (.*);
  gtof_listener gtof_listener_inst (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = !clock;
  end
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cmd2(input logic [7:0] a, input logic [7:0] b);
    cmd_valid <= 1'b1;
    cmd_byte <= a;
    @(posedge clock) cmd_byte <= b;
    @(posedge clock) cmd_valid <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // A reading strobe can ride with the request, so a one-shot message
  // cannot start before the listener has been cleared
  task automatic talk(input string e, input logic addr,
                      input logic rv = 1'b0);
    int i;
    clr <= 1'b1;
    @(posedge clock) clr <= 1'b0;
    talk_addressed <= addr;
    reading_valid <= rv;
    @(posedge clock) talk_addressed <= 1'b0;
    reading_valid <= 1'b0;
    for (i = 0; i < 400 && got_last !== 1'b1; i++) @(posedge clock);
    check(8'(gtof_listener_inst.n), 8'(e.len()));
    for (i = 0; i < e.len(); i++) begin
      check(gtof_listener_inst.msg[i], e[i]);
    end
  endtask
  task automatic t_status;
    srq_pending <= 1'b1;
    cmd2(CH_U, CH_0);
    check(status_word_pending, 1'b1);
    talk({"STATABCDEFGH331:", cr, lf}, 1'b1);
    talk({"N+NP", rd, cr, lf}, 1'b1);
    check(status_byte[6], 1'b1);
    srq_pending <= 1'b0;
  endtask
  task automatic t_term;
    cmd2(CH_Y, CH_CAP_A);
    check(illegal_option_flag, 1'b1);
    foreign_illegal_cmd <= 1'b1;
    @(posedge clock) foreign_illegal_cmd <= 1'b0;
    @(posedge clock) check(illegal_command_flag, 1'b1);
    @(posedge clock) check(status_byte, 8'h23);
    status_byte_read <= 1'b1;
    @(posedge clock) status_byte_read <= 1'b0;
    @(posedge clock) check(illegal_option_flag, 1'b0);
    check(illegal_command_flag, 1'b0);
    talk({"N+NP", rd, cr, lf}, 1'b1);
    cmd2(CH_Y, CH_CR);
    talk({"N+NP", rd, lf, cr}, 1'b1);
    cmd2(CH_Y, 8'h25);
    talk({"N+NP", rd, "%"}, 1'b1);
    cmd2(CH_G, CH_1);
    cmd2(CH_Y, CH_DEL);
    talk(rd, 1'b1);
    dev_clear <= 1'b1;
    @(posedge clock) dev_clear <= 1'b0;
    talk({"N+NP", rd, cr, lf}, 1'b1);
    {meas_state, meas_negative} <= 3'h7;
    reading_valid <= 1'b1;
    @(posedge clock) reading_valid <= 1'b0;
    talk({"Z-NP", rd, cr, lf}, 1'b1);
    {meas_state, meas_negative} <= 3'h2;
  endtask
  task automatic t_only;
    int i;
    rst_n <= 1'b0;
    talk_only_position <= 1'b1;
    address_switch <= 5'h03;
    repeat (3) @(posedge clock) rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    check(talk_only_active, 1'b1);
    reading_valid <= 1'b1;
    @(posedge clock) reading_valid <= 1'b0;
    cmd2(CH_G, CH_1);
    cmd2(CH_U, CH_0);
    check(status_word_pending, 1'b0);
    for (i = 0; i < 300 && got_last !== 1'b1; i++) @(posedge clock);
    talk({"N+NP", rd, cr, lf}, 1'b1);
    // Free-run stops at once; the press arms, the next reading sends
    one_shot_mode <= 1'b1;
    single_press <= 1'b1;
    @(posedge clock) single_press <= 1'b0;
    repeat (3) @(posedge clock);
    talk({"N+NP", rd, cr, lf}, 1'b0, 1'b1);
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    {rst_n, cmd_valid, foreign_illegal_cmd, dev_clear, talk_addressed} = 0;
    {status_byte_read, srq_pending, busy_in, reading_valid, clr} = 0;
    {meas_negative, dry_circuit, talk_only_position, one_shot_mode} = 0;
    {single_press, ext_trigger, slow, cmd_byte, address_switch} = 0;
    {pulsed_drive, line_50hz, meas_state} = 4'hd;
    srq_mask = 8'h21;
    mode_digits = "ABCDEFGH";
    mantissa = "+1.23456";
    exponent = "E-3";
    cr = " ";
    lf = " ";
    cr[0] = CH_CR;
    lf[0] = CH_LF;
    rd = "+1.23456E-3";
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock) reading_valid <= 1'b1;
    @(posedge clock) reading_valid <= 1'b0;
    slow <= 1'b1;
    talk({"N+NP", rd, cr, lf}, 1'b1);
    slow <= 1'b0;
    t_status();
    t_term();
    t_only();
    conclude();
  end
endmodule
